// *** inc/eirq_defines.vh ***
// constants for the external interrupt detector of lines 0 to 5
`ifndef EIRQ_DEFINES_VH
`define EIRQ_DEFINES_VH
// register indices as printed; byte address is four times the index
`define EIRQ_IDX_CTRL_01 16'h7FD8
`define EIRQ_IDX_CTRL_23 16'h7FD9
`define EIRQ_IDX_CTRL_45 16'h7FDA
`define EIRQ_ADDR_CTRL_01 18'h1FF60
`define EIRQ_ADDR_CTRL_23 18'h1FF64
`define EIRQ_ADDR_CTRL_45 18'h1FF68
`define EIRQ_ADDR_W 18
`define EIRQ_CTRL_RESET 8'h00
// field positions within a pair register
`define EIRQ_ODD_MODE_HI 7
`define EIRQ_ODD_MODE_LO 6
`define EIRQ_ODD_FLAG 5
`define EIRQ_ODD_EN 4
`define EIRQ_EVEN_MODE_HI 3
`define EIRQ_EVEN_MODE_LO 2
`define EIRQ_EVEN_FLAG 1
`define EIRQ_EVEN_EN 0
// detection modes
`define EIRQ_MODE_OFF 2'h0
`define EIRQ_MODE_LEVEL 2'h1
`define EIRQ_MODE_EDGE 2'h2
`define EIRQ_MODE_BOTH 2'h3
// vector addresses per line
`define EIRQ_VEC_LINE0 16'h800C
`define EIRQ_VEC_LINE1 16'h8014
`define EIRQ_VEC_LINE2 16'h8018
`define EIRQ_VEC_LINE3 16'h801C
`define EIRQ_VEC_LINE4 16'h8020
`define EIRQ_VEC_LINE5 16'h8024
`define EIRQ_VEC_NONE 16'h0000
`endif

// *** rtl/eirq_detect.v ***
// external interrupt detector for lines 0 to 5 with an apb register slave
//
// Operation
// RULE1: mode 00 off, 01 active level, 10 active edge, 11 both edges.
// RULE2: a line's flag sets whenever its input meets the selected condition.
// RULE3: flag stays set until software writes zero; hardware never clears it.
// RULE4: flag and enable both one raise request and standby release.
// RULE5: line 0 requests vector 800CH.
// RULE6: line 1 requests vector 8014H.
// RULE7: line 2 requests vector 8018H.
// RULE8: line 3 requests vector 801CH.
// RULE9: line 5 requests vector 8024H.
// RULE10: odd line mode 7:6, flag 5, enable 4; even 3:2, 1, 0.
// RULE11: one 8-bit read/write register per pair, at consecutive addresses.
// RULE12: line 4 requests vector 8020H.
// RULE13: port polarity setting inverts the pin before detection.
// RULE14: inputs pass two flops; edges compare current and previous sample.
//
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
`include "eirq_defines.vh"

module eirq_detect (
    input wire clock,
    input wire rst_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire [5:0] ext_irq_line,
    input wire [5:0] line_polarity_invert,
    output reg [5:0] irq_request,
    output reg [15:0] irq_vector,
    output reg deep_standby_keep_osc
);

    // ********************************
    // reset priming
    // ********************************
    // the edge compare needs two settled samples; without this a pin that
    // idles high looks like an edge right after reset
    reg [2:0] primed_q;
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            primed_q <= 3'h0;
        end else begin
            primed_q <= {primed_q[1:0], 1'b1};
        end
    end

    // polarity applied after sync to both samples; a polarity change alone never looks like an edge
    reg [5:0] inv_q;
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            inv_q <= 6'h00;
        end else begin
            inv_q <= line_polarity_invert;
        end
    end

    // ********************************
    // pair registers
    // ********************************
    reg [7:0] ctrl_q [0:2];
    wire [1:0] mode [0:5];
    wire [5:0] flag;
    wire [5:0] enab;
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : pair
            // RULE10
            assign mode[2*g] = ctrl_q[g][`EIRQ_EVEN_MODE_HI:`EIRQ_EVEN_MODE_LO];
            assign mode[2*g+1] = ctrl_q[g][`EIRQ_ODD_MODE_HI:`EIRQ_ODD_MODE_LO];
            assign flag[2*g] = ctrl_q[g][`EIRQ_EVEN_FLAG];
            assign flag[2*g+1] = ctrl_q[g][`EIRQ_ODD_FLAG];
            assign enab[2*g] = ctrl_q[g][`EIRQ_EVEN_EN];
            assign enab[2*g+1] = ctrl_q[g][`EIRQ_ODD_EN];
        end
    endgenerate

    // ********************************
    // detection
    // ********************************
    // each line has its own synchroniser and edge history
    wire [5:0] hit;

    eirq_line_detect u_eirq_line_detect_0 (
        .clock(clock),
        .rst_n(rst_n),
        .pin(ext_irq_line[0]),
        .invert(inv_q[0]),
        .mode(mode[0]),
        .primed(primed_q[2]),
        .hit(hit[0])
    );

    eirq_line_detect u_eirq_line_detect_1 (
        .clock(clock),
        .rst_n(rst_n),
        .pin(ext_irq_line[1]),
        .invert(inv_q[1]),
        .mode(mode[1]),
        .primed(primed_q[2]),
        .hit(hit[1])
    );

    eirq_line_detect u_eirq_line_detect_2 (
        .clock(clock),
        .rst_n(rst_n),
        .pin(ext_irq_line[2]),
        .invert(inv_q[2]),
        .mode(mode[2]),
        .primed(primed_q[2]),
        .hit(hit[2])
    );

    eirq_line_detect u_eirq_line_detect_3 (
        .clock(clock),
        .rst_n(rst_n),
        .pin(ext_irq_line[3]),
        .invert(inv_q[3]),
        .mode(mode[3]),
        .primed(primed_q[2]),
        .hit(hit[3])
    );

    eirq_line_detect u_eirq_line_detect_4 (
        .clock(clock),
        .rst_n(rst_n),
        .pin(ext_irq_line[4]),
        .invert(inv_q[4]),
        .mode(mode[4]),
        .primed(primed_q[2]),
        .hit(hit[4])
    );

    eirq_line_detect u_eirq_line_detect_5 (
        .clock(clock),
        .rst_n(rst_n),
        .pin(ext_irq_line[5]),
        .invert(inv_q[5]),
        .mode(mode[5]),
        .primed(primed_q[2]),
        .hit(hit[5])
    );

    // ********************************
    // apb slave
    // ********************************
    wire acc;
    reg [2:0] reg_hot;
    wire okaddr;
    wire [2:0] wr_hit;
    reg [7:0] rd_byte;
    assign acc = psel & penable & ~pready;

    // one-hot register select from the low address bits
    always @* begin
        case (paddr[`EIRQ_ADDR_W-1:0])
            `EIRQ_ADDR_CTRL_01: begin
                reg_hot = 3'h1;
            end
            `EIRQ_ADDR_CTRL_23: begin
                reg_hot = 3'h2;
            end
            `EIRQ_ADDR_CTRL_45: begin
                reg_hot = 3'h4;
            end
            default: begin
                reg_hot = 3'h0;
            end
        endcase
    end
    // upper bits must be zero so that aliases answer with an error
    assign okaddr = (|reg_hot) & (paddr[31:`EIRQ_ADDR_W] == 14'h0000);
    assign wr_hit = {3{acc & pwrite & okaddr}} & reg_hot; // RULE11

    always @* begin
        case (reg_hot)
            3'h1: begin
                rd_byte = ctrl_q[0];
            end
            3'h2: begin
                rd_byte = ctrl_q[1];
            end
            3'h4: begin
                rd_byte = ctrl_q[2];
            end
            default: begin
                rd_byte = 8'h00;
            end
        endcase
    end

    // flag bits: hardware set wins over a software write of zero
    reg [7:0] ctrl_d [0:2];
    integer k;
    always @* begin
        for (k = 0; k < 3; k = k + 1) begin
            ctrl_d[k] = ctrl_q[k];
            if (wr_hit[k]) begin
                ctrl_d[k] = pwdata[7:0]; // RULE11
            end
            if (hit[2*k]) begin
                ctrl_d[k][`EIRQ_EVEN_FLAG] = 1'b1; // RULE2 RULE3
            end
            if (hit[2*k+1]) begin
                ctrl_d[k][`EIRQ_ODD_FLAG] = 1'b1; // RULE2 RULE3
            end
        end
    end

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q[0] <= `EIRQ_CTRL_RESET;
            ctrl_q[1] <= `EIRQ_CTRL_RESET;
            ctrl_q[2] <= `EIRQ_CTRL_RESET;
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            ctrl_q[0] <= ctrl_d[0];
            ctrl_q[1] <= ctrl_d[1];
            ctrl_q[2] <= ctrl_d[2];
            // one wait state: answer in the second access cycle
            pready <= acc;
            pslverr <= acc & ~okaddr;
            // read data is zero outside the answer cycle
            if (acc && !pwrite && okaddr) begin
                prdata <= {24'h000000, rd_byte}; // RULE11
            end else begin
                prdata <= 32'h00000000;
            end
        end
    end

    // ********************************
    // request and vector
    // ********************************
    wire [5:0] act;
    assign act = flag & enab; // RULE4
    reg [15:0] vec_d;
    always @* begin
        // lowest line wins when several are pending
        if (act[0]) begin
            vec_d = `EIRQ_VEC_LINE0; // RULE5
        end else if (act[1]) begin
            vec_d = `EIRQ_VEC_LINE1; // RULE6
        end else if (act[2]) begin
            vec_d = `EIRQ_VEC_LINE2; // RULE7
        end else if (act[3]) begin
            vec_d = `EIRQ_VEC_LINE3; // RULE8
        end else if (act[4]) begin
            vec_d = `EIRQ_VEC_LINE4; // RULE12
        end else if (act[5]) begin
            vec_d = `EIRQ_VEC_LINE5; // RULE9
        end else begin
            vec_d = `EIRQ_VEC_NONE;
        end
    end

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            irq_request <= 6'h00;
            irq_vector <= `EIRQ_VEC_NONE;
            deep_standby_keep_osc <= 1'b0;
        end else begin
            irq_request <= act; // RULE4
            irq_vector <= vec_d;
            deep_standby_keep_osc <= |act; // RULE4
        end
    end

endmodule

// ********************************
// one line: synchroniser, edge compare and mode decode
// ********************************
module eirq_line_detect (
    input wire clock,
    input wire rst_n,
    input wire pin,
    input wire invert,
    input wire [1:0] mode,
    input wire primed,
    output wire hit
);

    reg sync1_q;
    reg sync2_q;
    reg prev_q;
    wire cur_lvl;
    wire prv_lvl;
    reg hit_raw;

    // two flops before any logic reads the pin
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
        end else begin
            sync1_q <= pin; // RULE14
            sync2_q <= sync1_q; // RULE14
        end
    end

    // edge history: only the second flop feeds it
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= sync2_q; // RULE14
        end
    end

    // active level is low; inversion turns a high pin into the active level
    assign cur_lvl = sync2_q ^ invert; // RULE13
    assign prv_lvl = prev_q ^ invert; // RULE13

    always @* begin
        case (mode) // RULE1
            `EIRQ_MODE_LEVEL: begin
                hit_raw = ~cur_lvl;
            end
            `EIRQ_MODE_EDGE: begin
                hit_raw = prv_lvl & ~cur_lvl;
            end
            `EIRQ_MODE_BOTH: begin
                hit_raw = prv_lvl ^ cur_lvl;
            end
            default: begin
                hit_raw = 1'b0;
            end
        endcase
    end

    // no hit until the previous sample holds a real pin value
    assign hit = primed & hit_raw;

endmodule

// *** tb/eirq_detect_sva.sv ***
// port assertions for the external interrupt detector
`timescale 1ns/1ps
module eirq_detect_sva (
    input wire clock,
    input wire rst_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] paddr,
    input wire pready,
    input wire pslverr,
    input wire [5:0] irq_request,
    input wire [15:0] irq_vector,
    input wire deep_standby_keep_osc
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held");
    chk_ready_time: assert property (psel && penable && !pready |=> pready)
        else $error("ready late");
    chk_err_map: assert property (pready && paddr[31:18] != 0 |-> pslverr)
        else $error("no error on unmapped");
    chk_release_or: assert property (deep_standby_keep_osc == |irq_request)
        else $error("release wrong");
    chk_vec_zero: assert property (irq_request[0] |-> irq_vector == 16'h800C)
        else $error("vector 0 wrong");
    chk_vec_one: assert property (irq_request[1:0] == 2'h2 |-> irq_vector == 16'h8014)
        else $error("vector 1 wrong");
    chk_vec_two: assert property (irq_request[2:0] == 3'h4 |-> irq_vector == 16'h8018)
        else $error("vector 2 wrong");
    chk_vec_three: assert property (irq_request[3:0] == 4'h8 |-> irq_vector == 16'h801C)
        else $error("vector 3 wrong");
    chk_vec_four: assert property (irq_request[4:0] == 5'h10 |-> irq_vector == 16'h8020)
        else $error("vector 4 wrong");
    chk_vec_five: assert property (irq_request == 6'h20 |-> irq_vector == 16'h8024)
        else $error("vector 5 wrong");
    // a request may only drop one edge after a completed write
    chk_flag_sticky: assert property (|($past(irq_request) & ~irq_request) |-> $past(pready && pwrite))
        else $error("request dropped alone");
    cover property (pslverr);
    cover property (irq_request[5]);
    cover property ($fell(irq_request[0]));
endmodule
bind eirq_detect eirq_detect_sva u_eirq_detect_sva (.clock, .rst_n, .psel,
    .penable, .pwrite, .paddr, .pready, .pslverr, .irq_request, .irq_vector,
    .deep_standby_keep_osc);

// *** tb/eirq_pin_model.sv ***
// external pin sources feeding the detector
`timescale 1ns/1ps
module eirq_pin_model (
    input wire clock,
    input wire [5:0] level_cmd,
    output logic [5:0] ext_irq_line = 6'h3F
);
    // pins move just after an edge, never mid-cycle
    always @(posedge clock) begin
        ext_irq_line <= level_cmd;
    end
endmodule

// *** tb/eirq_detect_tb_top.sv ***
// self-checking bench for the external interrupt detector
`timescale 1ns/1ps
`include "eirq_defines.vh"
module eirq_detect_tb_top;
    logic clock = 1'h0, rst_n = 1'h0, psel = 1'h0, penable = 1'h0;
    logic pwrite = 1'h0, er;
    logic [31:0] paddr = '0, pwdata = '0, rd, a;
    logic [5:0] pins = 6'h3F, inv = 6'h0;
    wire [31:0] prdata;
    wire pready, pslverr, osc;
    wire [5:0] lines, req;
    wire [15:0] vec;
    int n_errors = 0, total_checks = 0;
    // mode, invert, expected flag after one falling pin edge
    logic [3:0] cs [6] = '{4'h0, 4'h5, 4'h9, 4'hD, 4'hA, 4'h7};
    logic [15:0] vt [6] = '{16'h800C, 16'h8014, 16'h8018, 16'h801C,
        16'h8020, 16'h8024};
    eirq_detect u_eirq_detect (.clock, .rst_n, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .ext_irq_line(lines),
        .line_polarity_invert(inv), .irq_request(req), .irq_vector(vec),
        .deep_standby_keep_osc(osc));
    eirq_pin_model u_eirq_pin_model (.clock, .level_cmd(pins),
        .ext_irq_line(lines));
    initial forever #5 clock = ~clock;
    task automatic chk(input string what, input logic [31:0] exp, got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL %s exp %h got %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [31:0] ad, d);
        @(posedge clock);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'h1;
        do @(posedge clock); while (pready !== 1'h1);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic complete_run();
        if (n_errors == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge clock);
        n_errors++;
        complete_run();
    end
    initial begin
        repeat (20) @(posedge clock);
        rst_n <= 1'h1;
        for (int p = 0; p < 3; p++) begin
            apb(1'h0, `EIRQ_ADDR_CTRL_01 + 4 * p, '0);
            chk("reset value", 32'h0, rd);
        end
        apb(1'h0, 32'h40000, '0);
        chk("unmapped error", 32'h1, er);
        apb(1'h1, `EIRQ_ADDR_CTRL_45, 32'hD0);
        apb(1'h0, `EIRQ_ADDR_CTRL_45, '0);
        chk("readback", 32'hD0, rd);
        foreach (cs[i]) begin
            apb(1'h1, `EIRQ_ADDR_CTRL_01, '0);
            inv <= {5'h0, cs[i][1]};
            pins <= 6'h3F;
            repeat (6) @(posedge clock);
            apb(1'h1, `EIRQ_ADDR_CTRL_01, {cs[i][3:2], 2'h1});
            pins <= 6'h3E;
            repeat (6) @(posedge clock);
            apb(1'h0, `EIRQ_ADDR_CTRL_01, '0);
            chk("mode flag", {cs[i][3:2], cs[i][0], 1'h1}, rd);
            chk("mode request", cs[i][0], req[0]);
        end
        for (int n = 0; n < 6; n++) begin
            a = `EIRQ_ADDR_CTRL_01 + 4 * (n / 2);
            apb(1'h1, `EIRQ_ADDR_CTRL_01, '0);
            inv <= 6'h0;
            pins <= 6'h3F;
            repeat (6) @(posedge clock);
            apb(1'h1, a, (n % 2) ? 32'h90 : 32'h09);
            pins <= ~(6'h1 << n);
            repeat (6) @(posedge clock);
            pins <= 6'h3F;
            repeat (6) @(posedge clock);
            chk("request", 32'h1 << n, req);
            chk("vector", vt[n], vec);
            chk("release", 32'h1, osc);
            apb(1'h0, a, '0);
            chk("flag field", (n % 2) ? 32'hB0 : 32'h0B, rd);
            apb(1'h1, a, (n % 2) ? 32'h90 : 32'h09);
            repeat (4) @(posedge clock);
            chk("cleared", 32'h0, {osc, req});
        end
        complete_run();
    end
endmodule
